// File: src/ipls_pkg.sv
// constants for the interrupt priority level select block
package ipls_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 8;
  localparam logic [ADDR_W-1:0] PRIO_A_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] PRIO_B_OFFSET = 12'h004;
  localparam logic [REG_W-1:0] PRIO_A_RESET = 8'h00;
  localparam logic [REG_W-1:0] PRIO_B_RESET = 8'h00;
  localparam int unsigned WIDE_TIMER1_BIT = 1;
  localparam int unsigned WIDE_TIMER2_BIT = 0;
  localparam int unsigned NARROW_TIMER01_BIT = 7;
  localparam int unsigned NARROW_TIMER23_BIT = 6;
  localparam int unsigned DMA_BIT = 5;
  localparam int unsigned SERIAL0_BIT = 3;
  localparam int unsigned SERIAL1_BIT = 2;
  localparam int unsigned SERIAL2_BIT = 1;
  localparam int unsigned SPARE_HI_BIT = 4;
  localparam int unsigned SPARE_LO_BIT = 0;
  localparam logic [REG_W-1:0] PRIO_A_WMASK = 8'h03;
  localparam logic [REG_W-1:0] PRIO_B_WMASK = 8'hFF;
endpackage

// File: src/ipls_reg8.sv
// one byte-wide software register with write mask and sync clear
`timescale 1ns/100ps
`default_nettype none
module ipls_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= RESET_VAL;
    end else if (clear_i) begin
      q_o <= RESET_VAL;
    end else if (we_i) begin
      q_o <= (wdata_i & WMASK) | (q_o & ~WMASK);
    end
  end
endmodule
`default_nettype wire

// File: src/ipls_level_map.sv
// maps the two priority registers onto per-group level outputs
`timescale 1ns/100ps
`default_nettype none
module ipls_level_map (
  input wire logic [7:0] prio_a_i,
  input wire logic [7:0] prio_b_i,
  output logic [7:0] level_o
);
  import ipls_pkg::*;
  // order: wt1, wt2, nt01, nt23, dma, ser0, ser1, ser2
  assign level_o = {prio_a_i[WIDE_TIMER1_BIT], prio_a_i[WIDE_TIMER2_BIT],
                    prio_b_i[NARROW_TIMER01_BIT], prio_b_i[NARROW_TIMER23_BIT],
                    prio_b_i[DMA_BIT], prio_b_i[SERIAL0_BIT],
                    prio_b_i[SERIAL1_BIT], prio_b_i[SERIAL2_BIT]};
endmodule
`default_nettype wire

// File: src/ipls_top.sv
// interrupt priority level select: APB registers and level outputs
`timescale 1ns/100ps
`default_nettype none
module ipls_top (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic STANDBY_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ipls_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [ipls_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [ipls_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic WIDE_TIMER1_LEVEL_O,
  output logic WIDE_TIMER2_LEVEL_O,
  output logic NARROW_TIMER01_LEVEL_O,
  output logic NARROW_TIMER23_LEVEL_O,
  output logic DMA_LEVEL_O,
  output logic SERIAL0_LEVEL_O,
  output logic SERIAL1_LEVEL_O,
  output logic SERIAL2_LEVEL_O
);
  import ipls_pkg::*;

  logic [REG_W-1:0] prio_a_q;
  logic [REG_W-1:0] prio_b_q;
  logic [7:0] level;
  logic access;
  logic hit_a;
  logic hit_b;
  logic mapped;
  logic wr_a;
  logic wr_b;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] prdata_q;
  logic pslverr_q;

  // the register cells and level map are fixed at one byte
  if (REG_W != 8 || REG_W > DATA_W) begin : g_bad_width
    $error("register width does not fit the byte cells or the data bus");
  end

  // zero-wait slave: answer in the first access cycle
  assign access = PSEL_I & PENABLE_I;
  assign hit_a = (PADDR_I == PRIO_A_OFFSET);
  assign hit_b = (PADDR_I == PRIO_B_OFFSET);
  assign mapped = hit_a | hit_b;
  // only the low byte lane holds register bits
  assign wr_a = access & PWRITE_I & hit_a & PSTRB_I[0];
  assign wr_b = access & PWRITE_I & hit_b & PSTRB_I[0];
  assign PREADY_O = access;

  // register A keeps only the two timer bits in this block
  ipls_reg8 #(
    .RESET_VAL(PRIO_A_RESET),
    .WMASK(PRIO_A_WMASK)
  ) u_prio_a (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .clear_i(STANDBY_I),
    .we_i(wr_a),
    .wdata_i(PWDATA_I[REG_W-1:0]),
    .q_o(prio_a_q)
  );

  // all eight bits stored, reserved ones included
  ipls_reg8 #(
    .RESET_VAL(PRIO_B_RESET),
    .WMASK(PRIO_B_WMASK)
  ) u_prio_b (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .clear_i(STANDBY_I),
    .we_i(wr_b),
    .wdata_i(PWDATA_I[REG_W-1:0]),
    .q_o(prio_b_q)
  );

  // bits 4 and 0 of b reach no level output, only the read data
  ipls_level_map u_map (
    .prio_a_i(prio_a_q),
    .prio_b_i(prio_b_q),
    .level_o(level)
  );

  always_comb begin
    rdata_d = '0;
    if (hit_a) begin
      rdata_d = {{(DATA_W-REG_W){1'b0}}, prio_a_q};
    end else if (hit_b) begin
      rdata_d = {{(DATA_W-REG_W){1'b0}}, prio_b_q};
    end
  end

  // read data registered at setup so it is stable in the access cycle
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prdata_q <= '0;
    end else if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
      prdata_q <= rdata_d;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pslverr_q <= 1'b0;
    end else if (PSEL_I & ~PENABLE_I) begin
      pslverr_q <= ~mapped;
    end
  end

  assign PRDATA_O = prdata_q;
  assign PSLVERR_O = access & pslverr_q;

  // levels are plain wires from flops: no extra latency
  assign {WIDE_TIMER1_LEVEL_O, WIDE_TIMER2_LEVEL_O, NARROW_TIMER01_LEVEL_O,
          NARROW_TIMER23_LEVEL_O, DMA_LEVEL_O, SERIAL0_LEVEL_O,
          SERIAL1_LEVEL_O, SERIAL2_LEVEL_O} = level;

  chk_write_b_takes: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> prio_b_q == $past(PWDATA_I[REG_W-1:0]))
    else $error("register b write not stored");

  chk_standby_clears: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    STANDBY_I
      |=> prio_b_q == PRIO_B_RESET && prio_a_q == PRIO_A_RESET)
    else $error("standby did not clear registers");

  chk_dma_level: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> DMA_LEVEL_O == $past(PWDATA_I[DMA_BIT]))
    else $error("dma level not updated");

  chk_nt01_level: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    NARROW_TIMER01_LEVEL_O == prio_b_q[NARROW_TIMER01_BIT])
    else $error("narrow timer 0/1 level mismatch");

  chk_nt23_level: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> NARROW_TIMER23_LEVEL_O == $past(PWDATA_I[NARROW_TIMER23_BIT]))
    else $error("narrow timer 2/3 level not updated");

  chk_wt1_level: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_a & ~STANDBY_I
      |=> WIDE_TIMER1_LEVEL_O == $past(PWDATA_I[WIDE_TIMER1_BIT]))
    else $error("wide timer 1 level not updated");

  chk_wt2_level: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_a & ~STANDBY_I
      |=> WIDE_TIMER2_LEVEL_O == $past(PWDATA_I[WIDE_TIMER2_BIT]))
    else $error("wide timer 2 level not updated");

  chk_serial_levels: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    {SERIAL0_LEVEL_O, SERIAL1_LEVEL_O, SERIAL2_LEVEL_O} ==
    {prio_b_q[SERIAL0_BIT], prio_b_q[SERIAL1_BIT], prio_b_q[SERIAL2_BIT]})
    else $error("serial levels mismatch");

  // register a moves with b on standby, so it must be held still here
  chk_spare_bits_inert: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    ($changed(prio_b_q[SPARE_HI_BIT]) || $changed(prio_b_q[SPARE_LO_BIT])) && $stable(prio_a_q)
      && $stable(prio_b_q[NARROW_TIMER01_BIT:DMA_BIT]) && $stable(prio_b_q[SERIAL0_BIT:SERIAL2_BIT])
      |-> $stable(level))
    else $error("spare bit moved a level");

  chk_hold_levels: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    ~wr_a & ~wr_b & ~STANDBY_I
      |=> $stable(level))
    else $error("level changed without write");

  // reset is asynchronous: every edge inside it must see the low levels
  chk_reset_levels_low: assert property (@(posedge CORE_CLK_I)
    RST_I
      |-> level == '0)
    else $error("levels not low during reset");

  chk_reset_reg_b: assert property (@(posedge CORE_CLK_I)
    RST_I
      |-> prio_b_q == PRIO_B_RESET)
    else $error("register b not cleared by reset");

  chk_reset_reg_a: assert property (@(posedge CORE_CLK_I)
    RST_I
      |-> prio_a_q == PRIO_A_RESET)
    else $error("register a not cleared by reset");

  chk_write_a_takes: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_a & ~STANDBY_I
      |=> prio_a_q == ($past(PWDATA_I[REG_W-1:0]) & PRIO_A_WMASK))
    else $error("register a write not stored");

  chk_standby_beats_write: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    STANDBY_I & (wr_a | wr_b)
      |=> prio_b_q == PRIO_B_RESET && prio_a_q == PRIO_A_RESET)
    else $error("write won over standby");

  chk_spare_hi_stored: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> prio_b_q[SPARE_HI_BIT] == $past(PWDATA_I[SPARE_HI_BIT]))
    else $error("spare high bit not stored");

  chk_spare_lo_stored: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> prio_b_q[SPARE_LO_BIT] == $past(PWDATA_I[SPARE_LO_BIT]))
    else $error("spare low bit not stored");

  chk_nt23_follows: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    NARROW_TIMER23_LEVEL_O == prio_b_q[NARROW_TIMER23_BIT])
    else $error("narrow timer 2/3 level mismatch");

  chk_dma_follows: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    DMA_LEVEL_O == prio_b_q[DMA_BIT])
    else $error("dma level mismatch");

  chk_wt1_follows: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    WIDE_TIMER1_LEVEL_O == prio_a_q[WIDE_TIMER1_BIT])
    else $error("wide timer 1 level mismatch");

  chk_wt2_follows: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    WIDE_TIMER2_LEVEL_O == prio_a_q[WIDE_TIMER2_BIT])
    else $error("wide timer 2 level mismatch");

  chk_nt01_write: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> NARROW_TIMER01_LEVEL_O == $past(PWDATA_I[NARROW_TIMER01_BIT]))
    else $error("narrow timer 0/1 level not updated");

  chk_serial_write: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> {SERIAL0_LEVEL_O, SERIAL1_LEVEL_O, SERIAL2_LEVEL_O} == $past(PWDATA_I[SERIAL0_BIT:SERIAL2_BIT]))
    else $error("serial levels not updated");

  chk_b_write_spares_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_b & ~STANDBY_I
      |=> $stable(prio_a_q))
    else $error("register b write moved register a");

  chk_a_write_spares_b: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    wr_a & ~STANDBY_I
      |=> $stable(prio_b_q))
    else $error("register a write moved register b");

  chk_b_holds: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    ~wr_b & ~STANDBY_I
      |=> $stable(prio_b_q))
    else $error("register b changed without write");

  chk_a_holds: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    ~wr_a & ~STANDBY_I
      |=> $stable(prio_a_q))
    else $error("register a changed without write");

  chk_a_unused_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (prio_a_q & ~PRIO_A_WMASK) == '0)
    else $error("register a holds bits outside this block");

  chk_read_b_data: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PSEL_I & ~PENABLE_I & ~PWRITE_I & hit_b
      |=> PRDATA_O == {{(DATA_W-REG_W){1'b0}}, $past(prio_b_q)})
    else $error("register b read data wrong");

  chk_read_a_data: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PSEL_I & ~PENABLE_I & ~PWRITE_I & hit_a
      |=> PRDATA_O == {{(DATA_W-REG_W){1'b0}}, $past(prio_a_q)})
    else $error("register a read data wrong");

  chk_read_upper_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PRDATA_O[DATA_W-1:REG_W] == '0)
    else $error("read data upper bits not zero");

  chk_ready_zero_wait: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PREADY_O == (PSEL_I & PENABLE_I))
    else $error("ready not given in first access cycle");

  chk_err_unmapped: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PSEL_I & ~PENABLE_I & ~mapped
      |=> PENABLE_I |-> PSLVERR_O)
    else $error("unmapped access gave no error");

  chk_err_mapped_low: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    PSEL_I & ~PENABLE_I & mapped
      |=> ~PSLVERR_O)
    else $error("mapped access gave an error");

  chk_err_idle_low: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    ~access
      |-> ~PSLVERR_O)
    else $error("error outside access phase");

  chk_unmapped_no_store: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    access & PWRITE_I & ~mapped & ~STANDBY_I
      |=> $stable(prio_a_q) && $stable(prio_b_q))
    else $error("unmapped write changed a register");
endmodule
`default_nettype wire

// File: bench/ipls_arb_model.sv
// bench partner: arbitration side sampling the level outputs
`timescale 1ns/100ps
`default_nettype none
module ipls_arb_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] level_i,
  output logic [7:0] seen_o
);
  // the arbiter takes the levels at every edge, so a lag shows here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) seen_o <= 8'h00;
    else seen_o <= level_i;
  end
endmodule
`default_nettype wire

// File: bench/tb_ipls_top.sv
// testbench: apb register accesses and level checks
`timescale 1ns/100ps
`default_nettype none
module tb_ipls_top;
  import ipls_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stby = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] pa = '0;
  logic [DATA_W-1:0] pwd = '0;
  logic [3:0] pst = 4'hF;
  logic [DATA_W-1:0] prd;
  logic [DATA_W-1:0] rd;
  logic rdy;
  logic perr;
  logic er;
  logic [7:0] lv;
  logic [7:0] seen;
  int miscompares = 0;
  int cmp_count = 0;
  ipls_top ipls_top_inst (.CORE_CLK_I(clk), .RST_I(rst), .STANDBY_I(stby), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(pst), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(perr), .WIDE_TIMER1_LEVEL_O(lv[7]), .WIDE_TIMER2_LEVEL_O(lv[6]), .NARROW_TIMER01_LEVEL_O(lv[5]),
    .NARROW_TIMER23_LEVEL_O(lv[4]), .DMA_LEVEL_O(lv[3]), .SERIAL0_LEVEL_O(lv[2]), .SERIAL1_LEVEL_O(lv[1]),
    .SERIAL2_LEVEL_O(lv[0]));
  ipls_arb_model ipls_arb_model_inst (.clk_i(clk), .rst_i(rst), .level_i(lv), .seen_o(seen));
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] lmap(input logic [7:0] a, input logic [7:0] b);
    return {24'h0, a[1], a[0], b[7], b[6], b[5], b[3], b[2], b[1]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // psel drops for one cycle between calls: simpler, costs a cycle
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 20) miscompares++;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, PRIO_A_OFFSET, '0);
    chk("reg_a", 32'h0, rd);
    apb(1'b0, PRIO_B_OFFSET, '0);
    chk("reg_b", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, PRIO_B_OFFSET, 32'h1 << i);
      @(posedge clk);
      chk("levels_b", lmap(8'h00, 8'h01 << i), {24'h0, lv});
      apb(1'b0, PRIO_B_OFFSET, '0);
      chk("reg_b", 32'h1 << i, rd);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, PRIO_A_OFFSET, 32'h1 << i);
      @(posedge clk);
      chk("levels_a", lmap(8'h01 << i, 8'h80), {24'h0, lv});
    end
    apb(1'b1, PRIO_A_OFFSET, 32'hFF);
    apb(1'b0, PRIO_A_OFFSET, '0);
    chk("reg_a", 32'h3, rd);
    chk("arbiter", lmap(8'h03, 8'h80), {24'h0, seen});
    pst <= 4'h0;
    apb(1'b1, PRIO_B_OFFSET, 32'hFF);
    pst <= 4'hF;
    apb(1'b0, PRIO_B_OFFSET, '0);
    chk("reg_b_nostrb", 32'h80, rd);
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    apb(1'b0, PRIO_B_OFFSET, '0);
    chk("reg_b_stby", 32'h0, rd);
    chk("err_mapped", 32'h0, {31'h0, er});
    apb(1'b0, PRIO_A_OFFSET, '0);
    chk("reg_a_stby", 32'h0, rd);
    chk("levels_stby", 32'h0, {24'h0, lv});
    apb(1'b0, 12'h010, '0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, PRIO_B_OFFSET, 32'hFF);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, PRIO_B_OFFSET, '0);
    chk("reg_b_rst", 32'h0, rd);
    chk("levels_rst", 32'h0, {24'h0, lv});
    complete_run();
  end
endmodule
`default_nettype wire
